// *** verilog/wdt_timer.sv ***
`timescale 1ns/10ps
`include "wdt_defs.svh"

// Notes on behaviour
// - An enable command starts the countdown and turns on the timeout interrupt together.
// - While locked, enable, interrupt clear, type, interrupt enable, reset enable and reload writes are ignored.
// - A lock status output reports locked when writes are blocked and unlocked otherwise.
// - An interrupt clear removes the pending timeout interrupt from the interrupt outputs.
// - Raw and masked interrupt status are given, 1 meaning active and 0 inactive.
// - An interrupt type command selects non-maskable, which holds until reset; standard after reset.
// - The non-maskable interrupt is still gated by the enable and stays pending until cleared.
// - A reload value is held, readable, and loaded into the counter at every zero.
// - A reload write while running loads the counter at once and counting continues.
// - A reload write of zero raises the timeout interrupt at once.
// - The counter is a 32-bit down counter whose first zero after enabling is the first timeout.
// - A second zero while the interrupt is uncleared and reset is enabled asserts system reset.
// - Clearing the interrupt before the second timeout reloads the counter and resumes counting.
// - A reset-enable control, writable only while unlocked, gates the second-timeout reset.
module wdt_timer #(
    parameter logic [31:0] LOAD_RESET = `WDT_LOAD_RST
) (
    input  wire logic              core_clk,   // system clock, 40 MHz
    input  wire logic              resetn,     // asynchronous reset, active low
    input  wire wdt_pkg::wdt_cmd_s cmd,        // one-cycle command strobes
    input  wire logic [31:0]       loadValue,  // reload value with loadWrite
    output logic [31:0]            countValue, // current counter value
    output logic [31:0]            reloadValue,// stored reload value
    output logic                   running,    // counter enabled
    output logic                   lockState,  // 1 while locked
    output logic                   intRaw,     // raw timeout status
    output logic                   intMasked,  // masked timeout status
    output logic                   intIrq,     // standard interrupt line
    output logic                   intNmi,     // non-maskable interrupt line
    output logic                   rstEnabled, // reset generation enabled
    output logic                   sysReset    // system reset request
);

    wdt_pkg::wdt_state_s st_r;
    wdt_pkg::wdt_state_s st_nxt;
    logic                wrOk;
    logic                zeroHit;

    // ****************************************************
    // decode helpers
    // ****************************************************
    // a count word that has run out
    function automatic logic isZero(input logic [31:0] v);
        return (v == `WDT_ZERO);
    endfunction

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_nxt  = st_r;
        wrOk    = !st_r.locked;
        zeroHit = st_r.running && isZero(st_r.count);

        if (cmd.unlock) begin
            st_nxt.locked = 1'b0;
        end else if (cmd.lock) begin
            st_nxt.locked = 1'b1;
        end

        if (wrOk && cmd.rstEnable) begin
            st_nxt.rstEn = 1'b1;
        end else if (wrOk && cmd.rstDisable) begin
            st_nxt.rstEn = 1'b0;
        end

        if (wrOk && cmd.intTypeNmi) begin
            st_nxt.nmiSel = 1'b1;
        end

        if (wrOk && (cmd.enable || cmd.intEnable)) begin
            st_nxt.intEn = 1'b1;
        end
        if (wrOk && cmd.enable && !st_r.running) begin
            st_nxt.running = 1'b1;
            st_nxt.count   = st_r.reload;
            st_nxt.state   = wdt_pkg::WDT_FIRST;
        end

        if (st_r.running && !zeroHit) begin
            st_nxt.count = st_r.count - `WDT_ONE;
        end

        if (wrOk && cmd.intClear) begin
            st_nxt.intRaw = 1'b0;
            if (st_r.running) begin
                st_nxt.count = st_r.reload;
            end
        end

        if (zeroHit) begin
            st_nxt.count = st_r.reload;
            case (st_r.state)
                wdt_pkg::WDT_FIRST: begin
                    if (st_r.intRaw && st_r.rstEn) begin
                        st_nxt.state = wdt_pkg::WDT_EXPIRED;
                    end
                end
                wdt_pkg::WDT_EXPIRED: begin
                end
                default: begin
                end
            endcase
            if (st_r.intRaw && st_r.rstEn) begin
                st_nxt.sysRst = 1'b1;
            end
            // first timeout sets interrupt, set beats clear
            st_nxt.intRaw = 1'b1;
        end

        if (wrOk && cmd.loadWrite) begin
            st_nxt.reload = loadValue;
            if (st_r.running) begin
                st_nxt.count = loadValue;
            end
            if (isZero(loadValue)) begin
                st_nxt.intRaw = 1'b1;
            end
        end
    end

    // ****************************************************
    // state register
    // ****************************************************
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_r.state   <= wdt_pkg::WDT_IDLE;
            st_r.count   <= LOAD_RESET;
            st_r.reload  <= LOAD_RESET;
            st_r.running <= 1'b0;
            st_r.intEn   <= 1'b0;
            st_r.nmiSel  <= 1'b0;
            st_r.rstEn   <= 1'b0;
            st_r.locked  <= 1'b0;
            st_r.intRaw  <= 1'b0;
            st_r.sysRst  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign countValue  = st_r.count;
    assign reloadValue = st_r.reload;
    assign running     = st_r.running;
    assign lockState   = st_r.locked;
    assign rstEnabled  = st_r.rstEn;
    assign sysReset    = st_r.sysRst;
    assign intRaw      = st_r.intRaw;
    assign intMasked   = st_r.intRaw && st_r.intEn;
    assign intIrq      = intMasked && !st_r.nmiSel;
    assign intNmi      = intMasked && st_r.nmiSel;

    // ****************************************************
    // assertions
    // ****************************************************
    sequence s_firstZero;
        running && isZero(countValue) && !intRaw;
    endsequence

    sequence s_zeroArmed;
        running && isZero(countValue) && intRaw && rstEnabled;
    endsequence

    sequence s_clearTaken;
        cmd.intClear && !lockState && running && !isZero(countValue) && !cmd.loadWrite;
    endsequence

    sequence s_enableTaken;
        cmd.enable && !lockState && !running && !cmd.loadWrite;
    endsequence

    a_enable_starts: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.enable && !lockState && !running) |=> (running && intMasked == intRaw))
        else $error("enable did not start counter");
    a_enable_loads: assert property (@(posedge core_clk) disable iff (!resetn)
        s_enableTaken |=> (countValue == reloadValue))
        else $error("enable did not load counter");
    a_lock_blocks: assert property (@(posedge core_clk) disable iff (!resetn)
        (lockState && cmd.loadWrite && !cmd.unlock) |=> $stable(reloadValue))
        else $error("reload changed while locked");
    a_lock_enable: assert property (@(posedge core_clk) disable iff (!resetn)
        (lockState && cmd.enable && !running) |=> !running)
        else $error("enable taken while locked");
    a_lock_rstctl: assert property (@(posedge core_clk) disable iff (!resetn)
        (lockState && (cmd.rstEnable || cmd.rstDisable)) |=> $stable(rstEnabled))
        else $error("reset control changed while locked");
    a_lock_clear: assert property (@(posedge core_clk) disable iff (!resetn)
        (lockState && intRaw) |=> intRaw)
        else $error("interrupt cleared while locked");
    a_lock_state: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.lock && !cmd.unlock) |=> lockState)
        else $error("lock not reported");
    a_clear_drops: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.intClear && !lockState && !(running && isZero(countValue)) && !cmd.loadWrite) |=> !intRaw)
        else $error("clear did not drop interrupt");
    a_masked_stat: assert property (@(posedge core_clk) disable iff (!resetn)
        intMasked |-> intRaw)
        else $error("masked without raw");
    a_one_line: assert property (@(posedge core_clk) disable iff (!resetn)
        intMasked |-> (intIrq != intNmi))
        else $error("interrupt line selection wrong");
    a_nmi_route: assert property (@(posedge core_clk) disable iff (!resetn)
        intNmi |-> (intMasked && !intIrq))
        else $error("nmi routing wrong");
    a_line_gated: assert property (@(posedge core_clk) disable iff (!resetn)
        (intIrq || intNmi) |-> intMasked)
        else $error("interrupt line without enable");
    a_nmi_pending: assert property (@(posedge core_clk) disable iff (!resetn)
        (intNmi && !(cmd.intClear && !lockState)) |=> intNmi)
        else $error("nmi dropped without clear");
    a_first_timeout: assert property (@(posedge core_clk) disable iff (!resetn)
        s_firstZero |=> (intRaw && !$rose(sysReset)))
        else $error("first timeout missed");
    a_zero_reload: assert property (@(posedge core_clk) disable iff (!resetn)
        (running && isZero(countValue) && !cmd.loadWrite) |=> (countValue == reloadValue))
        else $error("zero did not reload counter");
    a_load_running: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.loadWrite && !lockState && running)
            |=> (countValue == $past(loadValue) && reloadValue == $past(loadValue)))
        else $error("reload write not loaded");
    a_zero_load: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.loadWrite && !lockState && isZero(loadValue)) |=> intRaw)
        else $error("zero load no interrupt");
    a_count_step: assert property (@(posedge core_clk) disable iff (!resetn)
        (running && !isZero(countValue) && cmd == '0) |=> (countValue == $past(countValue) - `WDT_ONE))
        else $error("counter did not step down");
    a_idle_hold: assert property (@(posedge core_clk) disable iff (!resetn)
        (!running && !cmd.enable) |=> $stable(countValue))
        else $error("idle counter moved");
    a_second_reset: assert property (@(posedge core_clk) disable iff (!resetn)
        s_zeroArmed |=> sysReset)
        else $error("second timeout no reset");
    a_no_early_rst: assert property (@(posedge core_clk) disable iff (!resetn)
        (!sysReset && !(running && isZero(countValue) && intRaw && rstEnabled)) |=> !sysReset)
        else $error("reset without second timeout");
    a_reset_sticky: assert property (@(posedge core_clk) disable iff (!resetn)
        sysReset |=> sysReset)
        else $error("system reset dropped");
    a_clear_reload: assert property (@(posedge core_clk) disable iff (!resetn)
        s_clearTaken |=> (!intRaw && countValue == reloadValue))
        else $error("clear did not reload counter");
    a_rst_on: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.rstEnable && !lockState) |=> rstEnabled)
        else $error("reset enable not set");
    a_rst_off: assert property (@(posedge core_clk) disable iff (!resetn)
        (cmd.rstDisable && !cmd.rstEnable && !lockState) |=> !rstEnabled)
        else $error("reset enable not cleared");
    a_unlock_ok: assert property (@(posedge core_clk) disable iff (!resetn)
        cmd.unlock |=> !lockState)
        else $error("unlock not taken");
    a_stay_running: assert property (@(posedge core_clk) disable iff (!resetn)
        running |=> running)
        else $error("counter stopped");

endmodule

// *** verilog/wdt_defs.svh ***
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

`define WDT_CNT_W      32
`define WDT_ZERO       32'h0000_0000
`define WDT_ONE        32'h0000_0001
`define WDT_LOAD_RST   32'hFFFF_FFFF

`endif

// *** verilog/wdt_pkg.sv ***
package wdt_pkg;

    typedef enum logic [2:0] {
        WDT_IDLE    = 3'b001,
        WDT_FIRST   = 3'b010,
        WDT_EXPIRED = 3'b100
    } wdt_state_e;

    typedef struct packed {
        logic enable;
        logic intClear;
        logic intEnable;
        logic intTypeNmi;
        logic rstEnable;
        logic rstDisable;
        logic lock;
        logic unlock;
        logic loadWrite;
    } wdt_cmd_s;

    typedef struct packed {
        wdt_state_e  state;
        logic [31:0] count;
        logic [31:0] reload;
        logic        running;
        logic        intEn;
        logic        nmiSel;
        logic        rstEn;
        logic        locked;
        logic        intRaw;
        logic        sysRst;
    } wdt_state_s;

endpackage

// *** sim/watchdog_timer_control_test.sv ***
`timescale 1ns/10ps

`define CHECK(got, exp) \
    begin \
        nTests++; \
        if ((got) !== (exp)) begin \
            failures++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

module watchdog_timer_control_test;
    // **********************************
    // command bit positions within the command struct
    // **********************************
    localparam logic [8:0] ENA = 9'h100, CLR = 9'h080, IEN = 9'h040, TNMI = 9'h020;
    localparam logic [8:0] RSTE = 9'h010, RSTD = 9'h008, LCK = 9'h004, ULK = 9'h002, LDW = 9'h001;

    logic              core_clk;
    logic              resetn;
    wdt_pkg::wdt_cmd_s cmd;
    logic [31:0]       loadValue;
    logic [31:0]       countValue;
    logic [31:0]       reloadValue;
    logic              running;
    logic              lockState;
    logic              intRaw;
    logic              intMasked;
    logic              intIrq;
    logic              intNmi;
    logic              rstEnabled;
    logic              sysReset;
    int                failures = 0;
    int                nTests   = 0;

    wdt_timer u_wdt_timer (
        .core_clk   (core_clk),
        .resetn     (resetn),
        .cmd        (cmd),
        .loadValue  (loadValue),
        .countValue (countValue),
        .reloadValue(reloadValue),
        .running    (running),
        .lockState  (lockState),
        .intRaw     (intRaw),
        .intMasked  (intMasked),
        .intIrq     (intIrq),
        .intNmi     (intNmi),
        .rstEnabled (rstEnabled),
        .sysReset   (sysReset)
    );

    initial core_clk = 1'b0;
    always #12.5 core_clk = ~core_clk;

    // **********************************
    // drivers
    // **********************************
    // one-cycle strobe; returns just after the edge where its effect lands
    task automatic cmdPulse(input logic [8:0] bits, input logic [31:0] val);
        @(posedge core_clk);
        cmd       <= wdt_pkg::wdt_cmd_s'(bits);
        loadValue <= val;
        @(posedge core_clk);
        cmd <= '0;
        #1;
    endtask

    task automatic waitRaw();
        int n;
        n = 0;
        while (intRaw !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHECK(intRaw, 1'b1)
    endtask

    // **********************************
    // scenarios
    // **********************************
    task automatic s_reset_values();
        `CHECK(countValue, 32'hFFFFFFFF)
        `CHECK(reloadValue, 32'hFFFFFFFF)
        `CHECK({running, lockState, intRaw, intIrq, intNmi, rstEnabled, sysReset}, 7'h00)
    endtask

    task automatic s_first_timeout();
        cmdPulse(LDW, 32'h00000003);
        cmdPulse(ENA, 32'h0);
        `CHECK(running, 1'b1)
        `CHECK(countValue, 32'h00000003)
        waitRaw();
        `CHECK({intMasked, intIrq, intNmi}, 3'h6)
        `CHECK(reloadValue, 32'h00000003)
    endtask

    task automatic s_reload_running();
        cmdPulse(LDW, 32'h000003E8);
        `CHECK(countValue, 32'h000003E8)
        @(posedge core_clk);
        #1;
        `CHECK(countValue, 32'h000003E7)
    endtask

    task automatic s_clear_and_stay();
        cmdPulse(CLR, 32'h0);
        `CHECK({intRaw, intMasked, intIrq}, 3'h0)
        `CHECK(countValue, 32'h000003E8)
        cmdPulse(ENA, 32'h0);
        `CHECK(running, 1'b1)
        `CHECK(countValue, 32'h000003E6)
    endtask

    task automatic s_lock();
        cmdPulse(LCK, 32'h0);
        `CHECK(lockState, 1'b1)
        cmdPulse(LDW, 32'h00000005);
        cmdPulse(RSTE | TNMI, 32'h0);
        `CHECK(reloadValue, 32'h000003E8)
        `CHECK({rstEnabled, intNmi}, 2'h0)
        cmdPulse(ULK, 32'h0);
        `CHECK(lockState, 1'b0)
    endtask

    task automatic s_zero_nmi();
        cmdPulse(TNMI, 32'h0);
        cmdPulse(LDW, 32'h00000000);
        `CHECK(intRaw, 1'b1)
        `CHECK({intMasked, intIrq, intNmi}, 3'h5)
        cmdPulse(LDW, 32'h000003E8);
        cmdPulse(CLR, 32'h0);
        `CHECK({intRaw, intNmi}, 2'h0)
    endtask

    task automatic s_second_timeout();
        int n;
        cmdPulse(RSTE, 32'h0);
        `CHECK(rstEnabled, 1'b1)
        cmdPulse(RSTD, 32'h0);
        `CHECK(rstEnabled, 1'b0)
        cmdPulse(RSTE, 32'h0);
        cmdPulse(LDW, 32'h00000003);
        waitRaw();
        `CHECK(sysReset, 1'b0)
        n = 0;
        while (sysReset !== 1'b1 && n < 40) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        `CHECK(sysReset, 1'b1)
        repeat (5) @(posedge core_clk);
        #1;
        `CHECK(sysReset, 1'b1)
    endtask

    // reset in mid-run clears the sticky reset request and all settings
    task automatic s_mid_reset();
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        s_reset_values();
    endtask

    task automatic s_int_enable();
        cmdPulse(LDW, 32'h00000000);
        `CHECK({running, intRaw, intMasked}, 3'h2)
        cmdPulse(IEN, 32'h0);
        `CHECK({running, intMasked, intIrq, intNmi}, 4'h6)
        cmdPulse(CLR, 32'h0);
        `CHECK({intRaw, intMasked}, 2'h0)
    endtask

    // **********************************
    // sequence and verdict
    // **********************************
    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", nTests, failures);
        if (failures == 0 && nTests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        resetn    = 1'b0;
        cmd       = '0;
        loadValue = 32'h0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        #1;
        s_reset_values();
        s_first_timeout();
        s_reload_running();
        s_clear_and_stay();
        s_lock();
        s_zero_nmi();
        s_second_timeout();
        s_mid_reset();
        s_int_enable();
        print_verdict();
    end

    initial begin
        #(25 * 3000);
        failures++;
        print_verdict();
    end
endmodule
